// *** hdl/iopd_regs.sv ***
// What this block does
// (R1) Bit 10 gates UART data pins, reset 1
// (R2) Bit 9 gates second counter pins, reset 1
// (R3) Bit 8 gates first counter pins, reset 1
// (R4) Bit 7 gates twelve serial pins, reset 1
// (R5) Bit 6 gates pulse output pin, reset 1
// (R6) Bit 5 gates four GPIO pins, reset 0
// (R7) Bit 4 gates 27 host pins, reset 0
// (R8) Bit 3 gates extmem sub2 pins, reset 0
// (R9) Bit 2 gates extmem sub1 pins, reset 0
// (R10) Bit 1 gates extmem sub0 pins, reset 0
// (R11) Bit 0 gates clock output pin, reset 0
// (R12) One means pins off, outputs Hi-Z
// (R13) Clocking starts in PLL bypass after reset
// (R14) Bits 31 to 14 read zero
// (R15) Software sets bit 13 at init
// (R16) Bit 12 extmem sub3 reset 0; 11 flow reset 1
// (R17) Register touches only pad buffer power
// (R18) Reads return bits; writes update all at once
//
// The implementer's own choices: strobed register access and the address map.
`include "iopd_defs.svh"

module iopd_regs (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Register port
  input  wire logic [`IOPD_ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // PLL controller reports reprogramming done
  input  wire logic                       pll_programmed,
  output logic                            pll_bypass,
  // Per-group powerdown levels
  output logic      [`IOPD_NUM_BITS-1:0]  group_off,
  // Clock output pad
  input  wire logic                       clock_output_pad_off_core_out,
  input  wire logic                       clock_output_pad_off_core_oe,
  input  wire logic                       clock_output_pad_off_pad_in,
  output logic                            clock_output_pad_off_pad_out,
  output logic                            clock_output_pad_off_pad_oe,
  output logic                            clock_output_pad_off_core_in,
  // General purpose pads
  input  wire logic [`IOPD_PINS_GPIO-1:0] gpio_core_out,
  input  wire logic [`IOPD_PINS_GPIO-1:0] gpio_core_oe,
  input  wire logic [`IOPD_PINS_GPIO-1:0] gpio_pad_in,
  output logic      [`IOPD_PINS_GPIO-1:0] gpio_pad_out,
  output logic      [`IOPD_PINS_GPIO-1:0] gpio_pad_oe,
  output logic      [`IOPD_PINS_GPIO-1:0] gpio_core_in
);

  iopd_pkg::iopd_state_t s_q;
  iopd_pkg::iopd_state_t s_d;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == `IOPD_OFS_POWERDOWN) begin
      s_d.pwdn = reg_wdata[`IOPD_NUM_BITS-1:0];  // R18 R15
    end
    if (pll_programmed) begin
      s_d.pll_bypass = 1'b0;  // R13
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `IOPD_OFS_POWERDOWN: begin
          s_d.rdata = {18'h00000, s_q.pwdn};  // R14 R18
        end
        `IOPD_OFS_CLOCKING: begin
          s_d.rdata = {31'h0000_0000, s_q.pll_bypass};
        end
        default: begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q.pwdn       <= `IOPD_RESET_VAL;  // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R16
      s_q.pll_bypass <= 1'b1;  // R13
      s_q.rdata      <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata  = s_q.rdata;
  assign pll_bypass = s_q.pll_bypass;
  // Pad power levels leave this block on group_off
  assign group_off  = s_q.pwdn;  // R17

  // --------------------------------------------------------------------------
  // Pad gating for the groups whose pins live here
  // --------------------------------------------------------------------------
  iopd_pad_gate #(.N(1)) u_clock_output_pad_off (
    .off      (s_q.pwdn[`IOPD_BIT_CLOCK_OUTPUT_PAD_OFF]),  // R11
    .core_out (clock_output_pad_off_core_out),
    .core_oe  (clock_output_pad_off_core_oe),
    .pad_in   (clock_output_pad_off_pad_in),
    .pad_out  (clock_output_pad_off_pad_out),
    .pad_oe   (clock_output_pad_off_pad_oe),
    .core_in  (clock_output_pad_off_core_in)
  );

  iopd_pad_gate #(.N(`IOPD_PINS_GPIO)) u_gpio (
    .off      (s_q.pwdn[`IOPD_BIT_GPIO]),  // R6
    .core_out (gpio_core_out),
    .core_oe  (gpio_core_oe),
    .pad_in   (gpio_pad_in),
    .pad_out  (gpio_pad_out),
    .pad_oe   (gpio_pad_oe),
    .core_in  (gpio_core_in)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_write_takes;
    @(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == `IOPD_OFS_POWERDOWN)
      |=> (group_off == $past(reg_wdata[`IOPD_NUM_BITS-1:0]));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("write not taken");  // R18

  property p_read_back;
    @(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `IOPD_OFS_POWERDOWN)
      |=> (reg_rdata == {18'h00000, $past(group_off)});
  endproperty
  a_read_back: assert property (p_read_back) else $error("bad readback");  // R18

  property p_reserved_zero;
    @(posedge core_clk) disable iff (rst)
    reg_rdata[31:14] == 18'h00000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");  // R14

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    !(reg_wr && reg_addr == `IOPD_OFS_POWERDOWN) |=> $stable(group_off);
  endproperty
  a_hold: assert property (p_hold) else $error("bits changed");  // R18

  property p_gpio_hiz;
    @(posedge core_clk) disable iff (rst)
    group_off[`IOPD_BIT_GPIO] |-> (gpio_pad_oe == 4'h0);
  endproperty
  a_gpio_hiz: assert property (p_gpio_hiz) else $error("gpio driven");  // R6

  property p_gpio_on;
    @(posedge core_clk) disable iff (rst)
    !group_off[`IOPD_BIT_GPIO] |-> (gpio_pad_oe == gpio_core_oe);
  endproperty
  a_gpio_on: assert property (p_gpio_on) else $error("gpio blocked");  // R12

  property p_clock_output_pad_off_hiz;
    @(posedge core_clk) disable iff (rst)
    group_off[`IOPD_BIT_CLOCK_OUTPUT_PAD_OFF] |-> !clock_output_pad_off_pad_oe;
  endproperty
  a_clock_output_pad_off_hiz: assert property (p_clock_output_pad_off_hiz) else $error("clock_output_pad_off driven");  // R11

  property p_bypass_leave;
    @(posedge core_clk) disable iff (rst)
    $fell(pll_bypass) |-> $past(pll_programmed);
  endproperty
  a_bypass_leave: assert property (p_bypass_leave) else $error("bypass left early");  // R13

  property p_bypass_sticky;
    @(posedge core_clk) disable iff (rst)
    !pll_bypass |=> !pll_bypass;
  endproperty
  a_bypass_sticky: assert property (p_bypass_sticky) else $error("bypass returned");  // R13

  // --------------------------------------------------------------------------
  // Reset values seen at the first edge after release
  // --------------------------------------------------------------------------
  property p_rst_uart_data;
    @(posedge core_clk)
    $fell(rst) |-> group_off[`IOPD_BIT_UART_DATA];
  endproperty
  a_rst_uart_data: assert property (p_rst_uart_data) else $error("uart data not off");  // R1

  property p_rst_counter1;
    @(posedge core_clk)
    $fell(rst) |-> group_off[`IOPD_BIT_COUNTER1];
  endproperty
  a_rst_counter1: assert property (p_rst_counter1) else $error("counter1 not off");  // R2

  property p_rst_counter0;
    @(posedge core_clk)
    $fell(rst) |-> group_off[`IOPD_BIT_COUNTER0];
  endproperty
  a_rst_counter0: assert property (p_rst_counter0) else $error("counter0 not off");  // R3

  property p_rst_serial;
    @(posedge core_clk)
    $fell(rst) |-> group_off[`IOPD_BIT_SERIAL];
  endproperty
  a_rst_serial: assert property (p_rst_serial) else $error("serial not off");  // R4

  property p_rst_pulse_b;
    @(posedge core_clk)
    $fell(rst) |-> group_off[`IOPD_BIT_PULSE_B];
  endproperty
  a_rst_pulse_b: assert property (p_rst_pulse_b) else $error("pulse output not off");  // R5

  property p_rst_gpio;
    @(posedge core_clk)
    $fell(rst) |-> !group_off[`IOPD_BIT_GPIO];
  endproperty
  a_rst_gpio: assert property (p_rst_gpio) else $error("gpio not on");  // R6

  property p_rst_host;
    @(posedge core_clk)
    $fell(rst) |-> !group_off[`IOPD_BIT_HOST];
  endproperty
  a_rst_host: assert property (p_rst_host) else $error("host not on");  // R7

  property p_rst_extmem2;
    @(posedge core_clk)
    $fell(rst) |-> !group_off[`IOPD_BIT_EXTMEM2];
  endproperty
  a_rst_extmem2: assert property (p_rst_extmem2) else $error("extmem2 not on");  // R8

  property p_rst_extmem1;
    @(posedge core_clk)
    $fell(rst) |-> !group_off[`IOPD_BIT_EXTMEM1];
  endproperty
  a_rst_extmem1: assert property (p_rst_extmem1) else $error("extmem1 not on");  // R9

  property p_rst_extmem0;
    @(posedge core_clk)
    $fell(rst) |-> !group_off[`IOPD_BIT_EXTMEM0];
  endproperty
  a_rst_extmem0: assert property (p_rst_extmem0) else $error("extmem0 not on");  // R10

  property p_rst_clock_output_pad_off;
    @(posedge core_clk)
    $fell(rst) |-> !group_off[`IOPD_BIT_CLOCK_OUTPUT_PAD_OFF];
  endproperty
  a_rst_clock_output_pad_off: assert property (p_rst_clock_output_pad_off) else $error("clock_output_pad_off not on");  // R11

  property p_rst_extmem3;
    @(posedge core_clk)
    $fell(rst) |-> !group_off[`IOPD_BIT_EXTMEM3];
  endproperty
  a_rst_extmem3: assert property (p_rst_extmem3) else $error("extmem3 not on");  // R16

  property p_rst_uart_flow;
    @(posedge core_clk)
    $fell(rst) |-> group_off[`IOPD_BIT_UART_FLOW];
  endproperty
  a_rst_uart_flow: assert property (p_rst_uart_flow) else $error("uart flow not off");  // R16

  // --------------------------------------------------------------------------
  // Read port, clocking status and pad data gating
  // --------------------------------------------------------------------------
  property p_rdata_idle;
    @(posedge core_clk) disable iff (rst)
    !reg_rd |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers");  // R18

  property p_clock_read;
    @(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `IOPD_OFS_CLOCKING)
      |=> (reg_rdata == {31'h0000_0000, $past(pll_bypass)});
  endproperty
  a_clock_read: assert property (p_clock_read) else $error("bad clocking read");  // R13

  property p_unmapped_read;
    @(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr != `IOPD_OFS_POWERDOWN && reg_addr != `IOPD_OFS_CLOCKING)
      |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");  // R18

  property p_bypass_reset;
    @(posedge core_clk)
    $fell(rst) |-> pll_bypass;
  endproperty
  a_bypass_reset: assert property (p_bypass_reset) else $error("bypass not set");  // R13

  property p_clock_output_pad_off_on;
    @(posedge core_clk) disable iff (rst)
    !group_off[`IOPD_BIT_CLOCK_OUTPUT_PAD_OFF] |-> (clock_output_pad_off_pad_oe == clock_output_pad_off_core_oe);
  endproperty
  a_clock_output_pad_off_on: assert property (p_clock_output_pad_off_on) else $error("clock_output_pad_off blocked");  // R12

  property p_clock_output_pad_off_quiet;
    @(posedge core_clk) disable iff (rst)
    group_off[`IOPD_BIT_CLOCK_OUTPUT_PAD_OFF] |-> (!clock_output_pad_off_pad_out && !clock_output_pad_off_core_in);
  endproperty
  a_clock_output_pad_off_quiet: assert property (p_clock_output_pad_off_quiet) else $error("clock_output_pad_off data live");  // R12

  property p_gpio_quiet;
    @(posedge core_clk) disable iff (rst)
    group_off[`IOPD_BIT_GPIO] |-> (gpio_pad_out == 4'h0 && gpio_core_in == 4'h0);
  endproperty
  a_gpio_quiet: assert property (p_gpio_quiet) else $error("gpio data live");  // R12

  property p_gpio_data_on;
    @(posedge core_clk) disable iff (rst)
    !group_off[`IOPD_BIT_GPIO]
      |-> (gpio_pad_out == gpio_core_out && gpio_core_in == gpio_pad_in);
  endproperty
  a_gpio_data_on: assert property (p_gpio_data_on) else $error("gpio data blocked");  // R12

  c_write: cover property (@(posedge core_clk) reg_wr && reg_addr == `IOPD_OFS_POWERDOWN);
  c_read: cover property (@(posedge core_clk) reg_rd && reg_addr == `IOPD_OFS_POWERDOWN);
  c_gpio_off: cover property (@(posedge core_clk) $rose(group_off[`IOPD_BIT_GPIO]));
  c_pll: cover property (@(posedge core_clk) $fell(pll_bypass));
  c_gpio_pass: cover property (@(posedge core_clk) !group_off[`IOPD_BIT_GPIO] && gpio_core_oe == 4'hF);

endmodule

// *** hdl/iopd_defs.svh ***
`ifndef IOPD_DEFS_SVH
`define IOPD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define IOPD_ADDR_W            8
`define IOPD_OFS_POWERDOWN     8'h48
`define IOPD_OFS_CLOCKING      8'h4C

// ----------------------------------------------------------------------------
// Field positions of the powerdown register
// ----------------------------------------------------------------------------
`define IOPD_BIT_CLOCK_OUTPUT_PAD_OFF        0
`define IOPD_BIT_EXTMEM0       1
`define IOPD_BIT_EXTMEM1       2
`define IOPD_BIT_EXTMEM2       3
`define IOPD_BIT_HOST          4
`define IOPD_BIT_GPIO          5
`define IOPD_BIT_PULSE_B       6
`define IOPD_BIT_SERIAL        7
`define IOPD_BIT_COUNTER0      8
`define IOPD_BIT_COUNTER1      9
`define IOPD_BIT_UART_DATA     10
`define IOPD_BIT_UART_FLOW     11
`define IOPD_BIT_EXTMEM3       12
`define IOPD_BIT_MUST_SET      13
`define IOPD_NUM_BITS          14

// ----------------------------------------------------------------------------
// Reset values and pin counts per group
// ----------------------------------------------------------------------------
`define IOPD_RESET_VAL         14'h0FC0
`define IOPD_WRITE_MASK        32'h0000_3FFF
`define IOPD_PINS_CLOCK_OUTPUT_PAD_OFF       1
`define IOPD_PINS_EXTMEM0      21
`define IOPD_PINS_EXTMEM1      29
`define IOPD_PINS_EXTMEM2      3
`define IOPD_PINS_HOST         27
`define IOPD_PINS_GPIO         4
`define IOPD_PINS_PULSE_B      1
`define IOPD_PINS_SERIAL       12
`define IOPD_PINS_COUNTER      2
`define IOPD_PINS_UART         2
`define IOPD_PINS_EXTMEM3      8

// ----------------------------------------------------------------------------
// Clocking status register
// ----------------------------------------------------------------------------
`define IOPD_BIT_PLL_BYPASS    0
`define IOPD_BIT_PLL_SWLOCK    1

`endif

// *** hdl/iopd_pkg.sv ***
`include "iopd_defs.svh"

package iopd_pkg;

  typedef logic [`IOPD_NUM_BITS-1:0] iopd_ctrl_t;

  typedef struct packed {
    iopd_ctrl_t  pwdn;
    logic        pll_bypass;
    logic [31:0] rdata;
  } iopd_state_t;

endpackage

// *** hdl/iopd_pad_gate.sv ***
`include "iopd_defs.svh"

module iopd_pad_gate #(
  parameter int N = 1
) (
  // Powerdown control
  input  wire logic         off,
  // Inputs: core side and pad_in
  input  wire logic [N-1:0] core_out,
  input  wire logic [N-1:0] core_oe,
  input  wire logic [N-1:0] pad_in,
  // Outputs: pad side and core_in
  output logic      [N-1:0] pad_out,
  output logic      [N-1:0] pad_oe,
  output logic      [N-1:0] core_in
);

  // Powered-down buffer drives nothing and reads low
  for (genvar i = 0; i < N; i++) begin : g_pin
    assign pad_oe[i]  = core_oe[i] & ~off;  // R12
    assign pad_out[i] = core_out[i] & ~off;
    assign core_in[i] = pad_in[i] & ~off;
  end

endmodule

// *** verif/iopd_regs_test.sv ***
`include "iopd_defs.svh"

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module iopd_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                       core_clk = 1'b0;
  logic                       rst = 1'b1;
  logic [`IOPD_ADDR_W-1:0]    reg_addr = 8'h00;
  logic [31:0]                reg_wdata = 32'h0;
  logic                       reg_wr = 1'b0;
  logic                       reg_rd = 1'b0;
  logic [31:0]                reg_rdata;
  logic                       pll_programmed = 1'b0;
  logic                       pll_bypass;
  logic [`IOPD_NUM_BITS-1:0]  group_off;
  logic                       ck_o, ck_oe, ck_i;
  logic [`IOPD_PINS_GPIO-1:0] gp_o, gp_oe, gp_i;
  logic                       ck_co = 1'b1, ck_coe = 1'b0, ck_ci = 1'b1;
  logic [`IOPD_PINS_GPIO-1:0] gp_co = 4'hA, gp_coe = 4'h5, gp_ci = 4'hC;
  int                         fails = 0;
  int                         checks = 0;
  localparam logic [14:0]     PADS_ON = {1'b1, 1'b0, 1'b1, 4'hA, 4'h5, 4'hC};

  iopd_regs DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_programmed(pll_programmed),
    .pll_bypass(pll_bypass), .group_off(group_off), .clock_output_pad_off_core_out(ck_co),
    .clock_output_pad_off_core_oe(ck_coe), .clock_output_pad_off_pad_in(ck_ci), .clock_output_pad_off_pad_out(ck_o),
    .clock_output_pad_off_pad_oe(ck_oe), .clock_output_pad_off_core_in(ck_i), .gpio_core_out(gp_co), .gpio_core_oe(gp_coe),
    .gpio_pad_in(gp_ci), .gpio_pad_out(gp_o), .gpio_pad_oe(gp_oe), .gpio_core_in(gp_i));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------------------
  // Register port, reset and wrap-up tasks
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    #1;
  endtask

  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    do_reset();
    `CHK(group_off, 14'h0FC0)
    `CHK(pll_bypass, 1'b1)
    `CHK({ck_o, ck_oe, ck_i, gp_o, gp_oe, gp_i}, PADS_ON)
    @(posedge core_clk);
    ck_coe <= 1'b1;
    gp_coe <= 4'hF;
    #1;
    `CHK({ck_oe, gp_oe}, 5'h1F)
    @(posedge core_clk);
    ck_coe <= 1'b0;
    gp_coe <= 4'h5;
    rd(`IOPD_OFS_POWERDOWN, 32'h0000_0FC0);
    rd(`IOPD_OFS_CLOCKING, 32'h0000_0001);
    @(posedge core_clk);
    #1;
    `CHK(reg_rdata, 32'h0)
    wr(`IOPD_OFS_POWERDOWN, 32'h0000_2000);
    for (int i = 0; i < 14; i++) begin
      wr(`IOPD_OFS_POWERDOWN, 32'h1 << i);
      `CHK(group_off, 14'h1 << i)
      `CHK({ck_o, ck_oe, ck_i}, (i == 0) ? 3'h0 : 3'h5)
      `CHK({gp_o, gp_oe, gp_i}, (i == 5) ? 12'h0 : 12'hA5C)
    end
    wr(`IOPD_OFS_POWERDOWN, 32'hFFFF_FFFF);
    `CHK(group_off, 14'h3FFF)
    `CHK({ck_o, ck_oe, ck_i, gp_o, gp_oe, gp_i}, 15'h0)
    `CHK(pll_bypass, 1'b1)
    rd(`IOPD_OFS_POWERDOWN, 32'h0000_3FFF);
    wr(8'h50, 32'h0);
    `CHK(group_off, 14'h3FFF)
    rd(8'h50, 32'h0);
    wr(`IOPD_OFS_CLOCKING, 32'h0);
    `CHK(pll_bypass, 1'b1)
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= `IOPD_OFS_POWERDOWN;
    reg_wdata <= 32'h5555_2A96;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, 32'h0000_2A96)
    @(posedge core_clk);
    pll_programmed <= 1'b1;
    @(posedge core_clk);
    pll_programmed <= 1'b0;
    #1;
    `CHK(pll_bypass, 1'b0)
    rd(`IOPD_OFS_CLOCKING, 32'h0);
    `CHK(group_off, 14'h2A96)
    do_reset();
    `CHK(group_off, 14'h0FC0)
    `CHK(pll_bypass, 1'b1)
    wrap_up();
  end
endmodule
